// ### inc/aux_timer_pkg.sv
// Constants, field layouts and carrier types for the auxiliary timer control block.
package aux_timer_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CONTROL = 8'h10;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
   localparam logic [7:0] OFS_COUNT = 8'h1c;
   localparam logic [7:0] OFS_PRESCALE = 8'h20;

   // ----------------------------------------------------------------
   // Control register field positions
   // ----------------------------------------------------------------
   localparam int INPUT_LSB = 0;
   localparam int MODE_LSB = 3;
   localparam int RUN_BIT = 6;
   localparam int SWDIR_BIT = 7;
   localparam int EXTDIR_BIT = 8;
   localparam int REMOTE_BIT = 9;
   localparam int CLR_OTHER_BIT = 10;
   localparam int CLR_CORE_BIT = 11;
   localparam int IRQDIS_BIT = 12;
   localparam int EDGE_BIT = 13;
   localparam int DIRCHG_BIT = 14;
   localparam int RDIR_BIT = 15;

   // Interrupt status and mask bit positions.
   localparam int ST_EDGE = 0;
   localparam int ST_DIRCHG = 1;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [14:0] CONTROL_RESET = 15'h0000;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [1:0] IRQ_RESET = 2'h0;
   localparam logic [1:0] PRESCALE_RESET = 2'h0;

   // ----------------------------------------------------------------
   // Mode encodings
   // ----------------------------------------------------------------
   localparam logic [2:0] MODE_TIMER = 3'h0;
   localparam logic [2:0] MODE_COUNTER = 3'h1;
   localparam logic [2:0] MODE_GATED_LOW = 3'h2;
   localparam logic [2:0] MODE_GATED_HIGH = 3'h3;
   localparam logic [2:0] MODE_RELOAD = 3'h4;
   localparam logic [2:0] MODE_CAPTURE = 3'h5;
   localparam logic [2:0] MODE_INCR_ROT = 3'h6;
   localparam logic [2:0] MODE_INCR_EDGE = 3'h7;

   // ----------------------------------------------------------------
   // Prescaler: base factor as a power of two per common code
   // ----------------------------------------------------------------
   localparam int PSC_CNT_W = 12;
   localparam logic [3:0] PSC_SHIFT_CODE01 = 4'h2;
   localparam logic [3:0] PSC_SHIFT_CODE00 = 4'h3;
   localparam logic [3:0] PSC_SHIFT_CODE11 = 4'h4;
   localparam logic [3:0] PSC_SHIFT_CODE10 = 4'h5;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
   } ahb_req_t;

   typedef struct packed {
      logic count_input_pin;
      logic ext_direction_pin;
   } timer_pins_t;

   typedef struct packed {
      logic core_timer_run_bit;
      logic core_toggle_latch;
   } core_link_t;

   typedef struct packed {
      logic [14:0] ctrl;
      logic [15:0] count;
      logic [1:0] irq_status;
      logic [1:0] irq_mask;
      logic [1:0] prescale_code;
      logic [PSC_CNT_W-1:0] psc_cnt;
      logic cin_s1;
      logic cin_s2;
      logic cin_d;
      logic dpin_s1;
      logic dpin_s2;
      logic dpin_d;
      logic tl_d;
      logic dir_prev;
      logic clr_other;
      logic clr_core;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] hrdata;
   } aux_state_t;

endpackage

// ### core/aux_timer_control.sv
// Auxiliary 16-bit timer: control register, direction, prescaler, flags and AHB-Lite slave.
//
// Contract
// - Mode field bits 5:3 selects timer, counter, gated, reload, capture, incremental.
// - Local run bit 6 starts or stops the timer while remote control is off.
// - Remote control bit 9 hands run control to the core timer run bit.
// - External direction off: software bit 7 alone sets up (0) or down (1).
// - External direction on: count down when pin XOR software bit is one.
// - Read-only bit 15 always shows effective direction, one meaning down.
// - Count edge sets bit 13; it stays set until software clears it.
// - Direction change sets bit 14; it stays set until software clears it.
// - Bit 12 suppresses edge and direction interrupts in incremental modes.
// - With bit 10, falling direction pin edge clears the other auxiliary timer.
// - With bit 11, falling count pin edge clears the core timer.
// - Input field bits 2:0 meaning depends on the selected mode.
// - Timer and gated tick is module clock over base times two to input field.
// - Counter and reload codes pick pin or toggle latch edges; x00 disables.
//
// The AHB-Lite slave port was left to the implementer.
module aux_timer_control
   import aux_timer_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire ahb_req_t ahb_req,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire timer_pins_t pins,
   input wire core_link_t core_link,
   output logic [15:0] count_value,
   output logic count_down,
   output logic clear_other_aux_timer,
   output logic clear_core_timer,
   output logic irq
);

   // ----------------------------------------------------------------
   // State and decoded helpers
   // ----------------------------------------------------------------
   aux_state_t s;
   aux_state_t next_s;

   logic [2:0] mode_select;
   logic [2:0] input_param_select;
   logic eff_down;
   logic running;
   logic cin_rise;
   logic cin_fall;
   logic dpin_rise;
   logic dpin_fall;
   logic tl_rise;
   logic tl_fall;
   logic [3:0] base_shift;
   logic [3:0] psc_shift;
   logic [PSC_CNT_W-1:0] psc_mask;
   logic psc_tick;
   logic count_edge;
   logic step;
   logic incr_mode;
   logic irq_allowed;
   logic addr_take;

   assign mode_select = s.ctrl[MODE_LSB +: 3];
   assign input_param_select = s.ctrl[INPUT_LSB +: 3];

   // Effective direction; the pin is ignored unless external control is on.
   assign eff_down = s.ctrl[EXTDIR_BIT] ? (s.dpin_s2 ^ s.ctrl[SWDIR_BIT])
                                        : s.ctrl[SWDIR_BIT];

   // Run source: remote control overrides the local run bit entirely.
   assign running = s.ctrl[REMOTE_BIT] ? core_link.core_timer_run_bit
                                       : s.ctrl[RUN_BIT];

   // Pin edges are taken from the second synchroniser stage and its delayed copy; toggle latch edges from the raw input.
   assign cin_rise = s.cin_s2 & ~s.cin_d;
   assign cin_fall = ~s.cin_s2 & s.cin_d;
   assign dpin_rise = s.dpin_s2 & ~s.dpin_d;
   assign dpin_fall = ~s.dpin_s2 & s.dpin_d;
   assign tl_rise = core_link.core_toggle_latch & ~s.tl_d;
   assign tl_fall = ~core_link.core_toggle_latch & s.tl_d;

   // ----------------------------------------------------------------
   // Prescaler
   // ----------------------------------------------------------------
   // Base factor follows the non-linear common code, so a lookup is used.
   always_comb begin
      case (s.prescale_code)
         2'h1: base_shift = PSC_SHIFT_CODE01;
         2'h0: base_shift = PSC_SHIFT_CODE00;
         2'h3: base_shift = PSC_SHIFT_CODE11;
         default: base_shift = PSC_SHIFT_CODE10;
      endcase
   end

   // The free-running counter ticks when its low psc_shift bits are all ones,
   // which gives a period of exactly two to psc_shift module clocks.
   assign psc_shift = base_shift + {1'b0, input_param_select};
   assign psc_mask = PSC_CNT_W'((13'h1 << psc_shift) - 13'h1);
   assign psc_tick = (s.psc_cnt & psc_mask) == psc_mask;

   // ----------------------------------------------------------------
   // Count source selection per mode
   // ----------------------------------------------------------------
   // Capture mode does not count here; it falls to the default branch, which holds step low.
   always_comb begin
      count_edge = 1'b0;
      step = 1'b0;
      case (mode_select)
         MODE_TIMER: begin
            step = running & psc_tick;
         end
         MODE_GATED_LOW: begin
            step = running & psc_tick & ~s.cin_s2;
         end
         MODE_GATED_HIGH: begin
            step = running & psc_tick & s.cin_s2;
         end
         MODE_COUNTER, MODE_RELOAD: begin
            if (input_param_select[2]) begin
               count_edge = (input_param_select[0] & tl_rise) |
                            (input_param_select[1] & tl_fall);
            end else begin
               count_edge = (input_param_select[0] & cin_rise) |
                            (input_param_select[1] & cin_fall);
            end
            step = running & count_edge;
         end
         MODE_INCR_ROT, MODE_INCR_EDGE: begin
            // Codes with the top bit set are reserved and count nothing.
            if (!input_param_select[2]) begin
               count_edge = (input_param_select[0] & (cin_rise | cin_fall)) |
                            (input_param_select[1] & (dpin_rise | dpin_fall));
            end
            step = running & count_edge;
         end
         default: begin
            count_edge = 1'b0;
            step = 1'b0;
         end
      endcase
   end

   assign incr_mode = (mode_select == MODE_INCR_ROT) | (mode_select == MODE_INCR_EDGE);
   assign irq_allowed = ~(incr_mode & s.ctrl[IRQDIS_BIT]);

   assign addr_take = ahb_req.hsel & hready & (ahb_req.htrans == HTRANS_NONSEQ);

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      next_s = s;

      // Two-flop synchronisers for the pins; stage one feeds stage two only.
      next_s.cin_s1 = pins.count_input_pin;
      next_s.cin_s2 = s.cin_s1;
      next_s.cin_d = s.cin_s2;
      next_s.dpin_s1 = pins.ext_direction_pin;
      next_s.dpin_s2 = s.dpin_s1;
      next_s.dpin_d = s.dpin_s2;
      next_s.tl_d = core_link.core_toggle_latch;
      next_s.dir_prev = eff_down;
      next_s.psc_cnt = PSC_CNT_W'(s.psc_cnt + 1'b1);

      // Clear requests to neighbouring timers are one-cycle pulses.
      next_s.clr_other = s.ctrl[CLR_OTHER_BIT] & dpin_fall;
      next_s.clr_core = s.ctrl[CLR_CORE_BIT] & cin_fall;

      // Counting; a CPU write below takes priority in the same cycle.
      if (step) begin
         if (eff_down) begin
            next_s.count = 16'(s.count - 16'h1);
         end else begin
            next_s.count = 16'(s.count + 16'h1);
         end
      end

      // Data phase of a write captured in the previous address phase.
      if (s.wr_pend) begin
         case (s.wr_addr)
            OFS_CONTROL: begin
               next_s.ctrl = ahb_req.hwdata[14:0];
            end
            OFS_IRQ_STATUS: begin
               next_s.irq_status = s.irq_status & ~ahb_req.hwdata[1:0];
            end
            OFS_IRQ_MASK: begin
               next_s.irq_mask = ahb_req.hwdata[1:0];
            end
            OFS_COUNT: begin
               next_s.count = ahb_req.hwdata[15:0];
            end
            OFS_PRESCALE: begin
               next_s.prescale_code = ahb_req.hwdata[1:0];
            end
            default: begin
               next_s.wr_pend = 1'b0;
            end
         endcase
      end

      // Hardware sets win over a software clear in the same cycle.
      if (count_edge) begin
         next_s.ctrl[EDGE_BIT] = 1'b1;
         if (irq_allowed) begin
            next_s.irq_status[ST_EDGE] = 1'b1;
         end
      end
      if (eff_down != s.dir_prev) begin
         next_s.ctrl[DIRCHG_BIT] = 1'b1;
         if (irq_allowed) begin
            next_s.irq_status[ST_DIRCHG] = 1'b1;
         end
      end

      // Address phase bookkeeping.
      next_s.wr_pend = addr_take & ahb_req.hwrite;
      next_s.wr_addr = ahb_req.haddr[7:0];

      // Read data is built from the updated state so that a read right after
      // a write returns the written value without a wait state.
      if (addr_take && !ahb_req.hwrite) begin
         case (ahb_req.haddr[7:0])
            OFS_CONTROL: next_s.hrdata = {16'h0, eff_down, next_s.ctrl};
            OFS_IRQ_STATUS: next_s.hrdata = {30'h0, next_s.irq_status};
            OFS_IRQ_MASK: next_s.hrdata = {30'h0, next_s.irq_mask};
            OFS_COUNT: next_s.hrdata = {16'h0, next_s.count};
            OFS_PRESCALE: next_s.hrdata = {30'h0, next_s.prescale_code};
            default: next_s.hrdata = 32'h0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s <= '0;
         s.ctrl <= CONTROL_RESET;
         s.count <= COUNT_RESET;
         s.irq_status <= IRQ_RESET;
         s.irq_mask <= IRQ_RESET;
         s.prescale_code <= PRESCALE_RESET;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Zero wait states and an OKAY response on every transfer.
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s.hrdata;
   assign count_value = s.count;
   assign count_down = s.dir_prev;
   assign clear_other_aux_timer = s.clr_other;
   assign clear_core_timer = s.clr_core;
   assign irq = |(s.irq_status & s.irq_mask);

endmodule

// ### sim/aux_timer_properties.sv
// Concurrent port checks for the auxiliary timer control block.
module aux_timer_properties
   import aux_timer_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire ahb_req_t ahb_req,
   input wire logic hready,
   input wire timer_pins_t pins,
   input wire logic [15:0] count_value,
   input wire logic count_down,
   input wire logic clear_other_aux_timer,
   input wire logic clear_core_timer,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic wr_dp;
   // A write data phase may load the count, so steps are not judged just after it.
   always_ff @(posedge clk_sys) begin
      wr_dp <= ahb_req.hsel & hready & ahb_req.hwrite & (ahb_req.htrans == HTRANS_NONSEQ);
   end
   AST_CORE_PULSE: assert property (clear_core_timer |=> !clear_core_timer)
      else $error("core clear pulse too long");
   AST_OTHER_PULSE: assert property (clear_other_aux_timer |=> !clear_other_aux_timer)
      else $error("other clear pulse too long");
   AST_CORE_CAUSE: assert property (clear_core_timer |-> !$past(pins.count_input_pin, 3))
      else $error("core clear without falling count pin");
   AST_OTHER_CAUSE: assert property (clear_other_aux_timer |-> !$past(pins.ext_direction_pin, 3))
      else $error("other clear without falling direction pin");
   AST_UP_STEP: assert property (!$past(wr_dp) && count_value == $past(count_value) + 16'h1 |-> !count_down)
      else $error("upward step while direction is down");
   AST_DOWN_STEP: assert property (!$past(wr_dp) && count_value == $past(count_value) - 16'h1 |-> count_down)
      else $error("downward step while direction is up");
   AST_ONE_STEP: assert property (!$past(wr_dp) |-> 16'(count_value - $past(count_value)) inside {16'h0, 16'h1, 16'hffff})
      else $error("count moved by more than one");
   AST_RESET_VALUES: assert property ($past(rst) |-> count_value == 16'h0 && !irq && !count_down)
      else $error("outputs not at reset values");
endmodule

bind aux_timer_control aux_timer_properties aux_timer_properties_i (.clk_sys, .rst, .ahb_req,
   .hready, .pins, .count_value, .count_down, .clear_other_aux_timer, .clear_core_timer, .irq);

// ### sim/input_pin_source.sv
// Model of the external count and direction pins.
module input_pin_source
   import aux_timer_pkg::*;
(
   input wire logic clk_sys,
   output timer_pins_t pins
);
   timeunit 1ns;
   timeprecision 1ps;
   initial pins = 2'h3;
   // Each level holds four cycles, since shorter pulses may be lost in the synchroniser.
   task automatic drive(input logic cin, input logic dpin);
      @(posedge clk_sys);
      pins <= '{count_input_pin: cin, ext_direction_pin: dpin};
      repeat (4) @(posedge clk_sys);
   endtask
endmodule

// ### sim/aux_timer_control_tb.sv
// Self-checking bench for the auxiliary timer control block.
module aux_timer_control_tb import aux_timer_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   ahb_req_t ahb_req = '0;
   core_link_t core_link = '0;
   timer_pins_t pins;
   logic hready, hreadyout, hresp, count_down, clr_o, clr_c, irq;
   logic [31:0] hrdata, q;
   logic [15:0] count_value;
   int n_errors = 0, n_checks = 0, n_core = 0, n_other = 0, cycles = 0;
   assign hready = hreadyout;
   always #2.5 clk_sys = ~clk_sys;
   aux_timer_control aux_timer_control_i (.clk_sys, .rst, .ahb_req, .hready, .hreadyout, .hresp,
      .hrdata, .pins, .core_link, .count_value, .count_down, .clear_other_aux_timer(clr_o),
      .clear_core_timer(clr_c), .irq);
   input_pin_source input_pin_source_i (.clk_sys, .pins);
   // Pulse counters and the hang limit.
   always @(posedge clk_sys) begin
      n_core += (clr_c === 1'b1);
      n_other += (clr_o === 1'b1);
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         print_verdict();
      end
   end
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One single transfer; the wait on hready has no own limit, the hang counter ends it.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      ahb_req <= '{1'b1, {24'h0, a}, HTRANS_NONSEQ, w, 3'h2, ahb_req.hwdata};
      do @(posedge clk_sys); while (hready !== 1'b1);
      ahb_req.htrans <= 2'h0;
      ahb_req.hwdata <= d;
      do @(posedge clk_sys); while (hready !== 1'b1);
      q = hrdata;
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_dir;
      logic [3:0] row [6] = '{4'h8, 4'hb, 4'h4, 4'hd, 4'h7, 4'he};
      bus(0, OFS_CONTROL, 0);
      check(q, 0);
      check(hresp, 1'b0);
      bus(0, 8'h3c, 0);
      check(q, 0);
      foreach (row[i]) begin
         input_pin_source_i.drive(1'b1, row[i][3]);
         bus(1, OFS_CONTROL, {23'h0, row[i][2:1], 7'h0});
         bus(0, OFS_CONTROL, 0);
         check(q[15], row[i][0]);
         check(count_down, row[i][0]);
      end
      bus(1, OFS_CONTROL, 0);
      bus(1, OFS_CONTROL, 32'h80);
      bus(0, OFS_CONTROL, 0);
      check(q[14], 1);
      bus(1, OFS_CONTROL, 32'h80);
      bus(0, OFS_CONTROL, 0);
      check(q[14], 0);
   endtask
   // The free prescaler makes the first tick early, so the second gap is measured.
   task automatic t_psc;
      logic [1:0] code [4] = '{2'h1, 2'h0, 2'h3, 2'h2};
      logic [2:0] sel [4] = '{3'h0, 3'h0, 3'h1, 3'h2};
      int fac [4] = '{4, 8, 32, 128};
      int k;
      logic [15:0] c;
      foreach (fac[i]) begin
         bus(1, OFS_PRESCALE, {30'h0, code[i]});
         bus(1, OFS_CONTROL, {25'h0, 1'b1, 3'h0, sel[i]});
         @(negedge clk_sys);
         repeat (2) begin
            c = count_value;
            k = 0;
            do begin @(negedge clk_sys); k++; end while (count_value === c && k < 300);
         end
         check(k, fac[i]);
      end
   endtask
   task automatic t_cnt;
      logic [2:0] sel [7] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7, 3'h4};
      int exp [7] = '{1, 1, 2, 1, 1, 2, 0};
      int c0 = n_core;
      bus(1, OFS_IRQ_MASK, 1);
      foreach (sel[i]) begin
         bus(1, OFS_CONTROL, {20'h0, 1'b1, 4'h0, 1'b1, 3'h1, sel[i]});
         bus(1, OFS_COUNT, 0);
         bus(1, OFS_IRQ_STATUS, 3);
         input_pin_source_i.drive(1'b0, 1'b1);
         input_pin_source_i.drive(1'b1, 1'b1);
         core_link.core_toggle_latch <= 1'b1;
         repeat (4) @(posedge clk_sys);
         core_link.core_toggle_latch <= 1'b0;
         repeat (4) @(posedge clk_sys);
         bus(0, OFS_COUNT, 0);
         check(q, exp[i]);
         bus(0, OFS_CONTROL, 0);
         check(q[13], exp[i] != 0);
         check(irq, exp[i] != 0);
      end
      check(n_core - c0, 7);
   endtask
   task automatic t_incr;
      bus(1, OFS_IRQ_MASK, 3);
      for (int d = 1; d >= 0; d--) begin
         bus(1, OFS_CONTROL, {19'h0, d[0], 5'h0, 1'b1, 3'h6, 3'h1});
         bus(1, OFS_IRQ_STATUS, 3);
         input_pin_source_i.drive(!d[0], 1'b1);
         check(irq, !d[0]);
         bus(0, OFS_CONTROL, 0);
         check(q[13], 1);
      end
   endtask
   task automatic t_run;
      logic [31:0] cv [4] = '{32'h200, 32'h200, 32'h240, 32'h40};
      logic [1:0] rr [4] = '{2'h0, 2'h3, 2'h0, 2'h1};
      bus(1, OFS_PRESCALE, 1);
      foreach (cv[i]) begin
         core_link.core_timer_run_bit <= rr[i][1];
         bus(1, OFS_CONTROL, cv[i]);
         bus(1, OFS_COUNT, 0);
         repeat (40) @(posedge clk_sys);
         check(count_value != 0, rr[i][0]);
      end
   endtask
   // Gate level per mode: bit 1 of pe is the pin, bit 0 whether counting is expected.
   task automatic t_gate;
      logic [2:0] md [5] = '{3'h2, 3'h2, 3'h3, 3'h3, 3'h5};
      logic [1:0] pe [5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h2};
      bus(1, OFS_PRESCALE, 1);
      foreach (md[i]) begin
         input_pin_source_i.drive(pe[i][1], 1'b1);
         bus(1, OFS_CONTROL, {25'h0, 1'b1, md[i], 3'h0});
         bus(1, OFS_COUNT, 0);
         repeat (40) @(posedge clk_sys);
         check(count_value != 0, pe[i][0]);
      end
   endtask
   task automatic t_clr;
      for (int e = 1; e >= 0; e--) begin
         int c0;
         c0 = n_other;
         bus(1, OFS_CONTROL, {21'h0, e[0], 10'h0});
         input_pin_source_i.drive(1'b1, 1'b0);
         input_pin_source_i.drive(1'b1, 1'b1);
         check(n_other - c0, e);
      end
   endtask
   // Main sequence: four cycles of reset, then each scenario in turn.
   initial begin
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      t_dir();
      $display("direction test done");
      t_psc();
      $display("prescaler test done");
      t_cnt();
      $display("counter test done");
      t_incr();
      $display("incremental test done");
      t_run();
      $display("run control test done");
      t_gate();
      $display("gated test done");
      t_clr();
      $display("clear test done");
      print_verdict();
   end
endmodule
